/* common/fmp_pkg.sv */
`default_nettype none
// ==========================================================
// frame memory port constants and carriers
package fmp_pkg;
   // ==========================================================
   // memory geometry
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int SHIFT_W = 15;
   localparam int CNT_W = 4;
   localparam int BUF_DEPTH = 2;
   localparam int BLOCK_SHIFT = 5;
   localparam int GRID1_H_BITS = 5;
   localparam int GRID2_H_BITS = 6;
   localparam int V_BITS = 9;
   localparam logic [ADDR_W:0] TOTAL_WORDS = 20'h51000;
   localparam logic [ADDR_W-1:0] LINE_LEN_1 = 19'h00400;
   localparam logic [ADDR_W-1:0] LINE_LEN_2 = 19'h00480;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 19'h00000;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 19'h00001;
   localparam logic [CNT_W-1:0] JUMP_BITS_SHORT = 4'he;
   localparam logic [CNT_W-1:0] JUMP_BITS_LONG = 4'hf;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

   // ==========================================================
   // addressing modes, from the two mode pins {mode1, mode0}
   typedef enum logic [1:0] {
      FMP_LINEAR   = 2'b00,
      FMP_GRID1024 = 2'b01,
      FMP_GRID1152 = 2'b10
   } fmp_mode_t;

   // ==========================================================
   // per-port control pins, all active low except serial
   typedef struct packed {
      logic advanceGateN;   // pointer advance gate
      logic pointerResetN;  // pointer reset
      logic jumpStrobeN;    // jump address set / jump
      logic lineRestartN;   // line restart
      logic windowSelectN;  // window scan select
      logic pointerClearN;  // pointer clear
      logic jumpSerial;     // serial jump address bit
   } fmp_ctl_t;

   // per-port pointer state
   typedef struct packed {
      logic [ADDR_W-1:0] ptr;
      logic [ADDR_W-1:0] winStart;
      logic [ADDR_W-1:0] winLeft;
      logic [ADDR_W-1:0] jumpHold;
      logic [SHIFT_W-1:0] shiftReg;
      logic [CNT_W-1:0] shiftCnt;
      logic shifting;
      logic winOn;
      logic prevReset;
      logic prevStrobe;
      logic prevLine;
   } fmp_port_t;

   localparam fmp_port_t PORT_RESET = '{
      ptr: 19'h00000, winStart: 19'h00000, winLeft: 19'h00000,
      jumpHold: 19'h00000, shiftReg: 15'h0000, shiftCnt: 4'h0,
      shifting: 1'b0, winOn: 1'b0, prevReset: 1'b1, prevStrobe: 1'b1,
      prevLine: 1'b1
   };
endpackage
`default_nettype wire

/* hw/fmp_pair_buffer.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// small valid/ready buffer on the read data path
module fmp_pair_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic sys_clk,             // clock
   input wire logic resetn,              // sync reset, active low
   input wire logic ce,                  // clock enable
   input wire logic inValid,             // word offered
   output logic inReady,                 // room for a word
   input wire logic [WIDTH-1:0] inData,  // offered word
   output logic outValid,                // word available
   input wire logic outReady,            // receiver takes word
   output logic [WIDTH-1:0] outData      // head word
);
   localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

   logic [WIDTH-1:0] slot [DEPTH];
   logic [IDX_W-1:0] wrIdx, rdIdx, next_wrIdx, next_rdIdx;
   logic [CNT_W-1:0] count, next_count;
   logic push, pop;

   // ==========================================================
   // handshake and pointer arithmetic
   assign inReady = (count != FULL_CNT);
   assign outValid = (count != '0);
   assign outData = slot[rdIdx];

   always_comb begin
      push = inValid && inReady;
      pop = outValid && outReady;
      next_wrIdx = wrIdx;
      next_rdIdx = rdIdx;
      next_count = count;
      if (push) begin
         next_wrIdx = (wrIdx == LAST_IDX) ? '0 : IDX_W'(wrIdx + 1'b1);
      end
      if (pop) begin
         next_rdIdx = (rdIdx == LAST_IDX) ? '0 : IDX_W'(rdIdx + 1'b1);
      end
      if (push && !pop) begin
         next_count = CNT_W'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = CNT_W'(count - 1'b1);
      end
   end

   // register pointers, count and slots
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         wrIdx <= '0;
         rdIdx <= '0;
         count <= '0;
      end else if (ce) begin
         wrIdx <= next_wrIdx;
         rdIdx <= next_rdIdx;
         count <= next_count;
         if (push) begin
            slot[wrIdx] <= inData;
         end
      end
   end
endmodule
`default_nettype wire

/* hw/fmp_frame_memory.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// frame memory with write and read pointer control
// Summary of operation
// - store input byte when write advance gate and write enable are both low
// - write pointer advances on the storing edge while advance gate low
// - pointer advances regardless of write enable, skipping untouched locations
// - write enable high leaves addressed memory contents unchanged
// - write jump address arrives serially, 14 or 15 bits, from strobe fall
// - read bytes are delivered synchronous to the clock
// - read word when gate and output enable low; gate low advances pointer unless output enable low with buffer full
// - read jump address shifts serially from strobe fall, independent of output
// - write reset goes to zero, line head, or stored jump address
// - write reset acts on falling edge; next cycle uses new address
// - read reset goes to zero, line head, or stored jump address
// - read reset acts on falling edge; next cycle uses new address
// - window scan redirects zero to window start, line head to left edge
// - serial jump bits taken msb first starting in the strobe fall cycle
// - line restart fall goes to next line head, or current with reset low
// - clear low zeroes pointer and cancels window at once, over everything
// - linear mode wraps through all blocks back to block zero
module fmp_frame_memory (
   input wire logic sys_clk,                     // clock
   input wire logic resetn,                      // sync reset, active low
   input wire logic ce,                          // clock enable
   input wire fmp_pkg::fmp_mode_t mode,          // addressing mode pins
   input wire fmp_pkg::fmp_ctl_t writeCtl,       // write port control
   input wire logic writeEnableN,                // write data enable
   input wire logic [fmp_pkg::DATA_W-1:0] writeData, // write byte
   input wire fmp_pkg::fmp_ctl_t readCtl,        // read port control
   input wire logic outputEnableN,               // read output enable
   output logic [fmp_pkg::DATA_W-1:0] readData,  // read byte
   output logic readValid,                       // read byte valid
   input wire logic readReady,                   // receiver accepts byte
   output logic [fmp_pkg::ADDR_W-1:0] writePointer, // write pointer
   output logic [fmp_pkg::ADDR_W-1:0] readPointer   // read pointer
);
   import fmp_pkg::*;

   logic [DATA_W-1:0] mem [TOTAL_WORDS];
   fmp_port_t wrState, next_wrState, rdState, next_rdState;
   logic [ADDR_W-1:0] wrAddr, rdAddr;
   logic wrStore, rdFetch, rdAdvOk, bufReady;

   // ==========================================================
   // address helpers
   function automatic logic [ADDR_W-1:0] addWrap(input logic [ADDR_W-1:0] a,
                                                  input logic [ADDR_W-1:0] b);
      logic [ADDR_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s >= TOTAL_WORDS) begin
         s = s - TOTAL_WORDS;
      end
      return s[ADDR_W-1:0];
   endfunction

   function automatic logic [ADDR_W-1:0] lineLen(input fmp_mode_t m);
      unique case (m)
         FMP_GRID1024: return LINE_LEN_1;
         FMP_GRID1152: return LINE_LEN_2;
         default: return ADDR_ZERO;
      endcase
   endfunction

   function automatic logic [ADDR_W-1:0] lineHeadOf(input logic [ADDR_W-1:0] p,
                                                     input fmp_mode_t m);
      unique case (m)
         FMP_GRID1024: return {p[ADDR_W-1:10], 10'h000};
         FMP_GRID1152: return (p / LINE_LEN_2) * LINE_LEN_2;
         default: return ADDR_ZERO;
      endcase
   endfunction

   function automatic logic [CNT_W-1:0] jumpBits(input fmp_mode_t m);
      return (m == FMP_GRID1152) ? JUMP_BITS_LONG : JUMP_BITS_SHORT;
   endfunction

   // serial jump code to word address, 32-word blocks
   function automatic logic [ADDR_W-1:0] jumpToWord(input logic [SHIFT_W-1:0] j,
                                                     input fmp_mode_t m);
      logic [ADDR_W-1:0] v;
      logic [ADDR_W-1:0] h;
      v = ADDR_ZERO;
      h = ADDR_ZERO;
      unique case (m)
         FMP_GRID1024: begin
            v = ADDR_W'(j[GRID1_H_BITS +: V_BITS]);
            h = ADDR_W'(j[GRID1_H_BITS-1:0]);
            return {v[V_BITS-1:0], 10'h000} + (h << BLOCK_SHIFT);
         end
         FMP_GRID1152: begin
            v = ADDR_W'(j[GRID2_H_BITS +: V_BITS]);
            h = ADDR_W'(j[GRID2_H_BITS-1:0]);
            return ADDR_W'(v * LINE_LEN_2) + (h << BLOCK_SHIFT);
         end
         default: begin
            return {j[13:0], 5'h00};
         end
      endcase
   endfunction

   // ==========================================================
   // one port's pointer step, shared by both ports
   function automatic fmp_port_t stepPort(input fmp_port_t s, input fmp_ctl_t c,
                                          input fmp_mode_t m, input logic advOk);
      fmp_port_t n;
      logic fallR, fallS, fallL, grid, adv, doJump;
      logic [ADDR_W-1:0] head, left, len;
      n = s;
      n.prevReset = c.pointerResetN;
      n.prevStrobe = c.jumpStrobeN;
      n.prevLine = c.lineRestartN;
      fallR = s.prevReset && !c.pointerResetN;
      fallS = s.prevStrobe && !c.jumpStrobeN;
      fallL = s.prevLine && !c.lineRestartN;
      grid = (m != FMP_LINEAR);
      adv = !c.advanceGateN && advOk;
      head = lineHeadOf(s.ptr, m);
      len = lineLen(m);
      left = s.winOn ? s.winLeft : ADDR_ZERO;
      doJump = (fallR && !c.jumpStrobeN) || (!fallR && fallS && !c.pointerResetN);

      // serial jump address, msb first, independent of data
      if (s.shifting) begin
         n.shiftReg = {s.shiftReg[SHIFT_W-2:0], c.jumpSerial};
         n.shiftCnt = s.shiftCnt + CNT_ONE;
         if (n.shiftCnt == jumpBits(m)) begin
            n.shifting = 1'b0;
            n.jumpHold = jumpToWord(n.shiftReg, m);
         end
      end else if (fallS && c.pointerResetN) begin
         n.shifting = 1'b1;
         n.shiftReg = {{(SHIFT_W-1){1'b0}}, c.jumpSerial};
         n.shiftCnt = CNT_ONE;
      end

      // pointer moves, clear first
      if (!c.pointerClearN) begin
         n.ptr = adv ? ADDR_ONE : ADDR_ZERO;
         n.winOn = 1'b0;
      end else if (doJump) begin
         n.ptr = s.jumpHold;
         if (grid && !c.windowSelectN) begin
            n.winOn = 1'b1;
            n.winStart = s.jumpHold;
            n.winLeft = s.jumpHold - lineHeadOf(s.jumpHold, m);
         end
      end else if (fallR) begin
         if (grid && !c.lineRestartN) begin
            n.ptr = addWrap(head, left);
         end else begin
            n.ptr = s.winOn ? s.winStart : ADDR_ZERO;
         end
      end else if (fallL && grid) begin
         if (c.pointerResetN) begin
            n.ptr = addWrap(addWrap(head, len), left);
         end else begin
            n.ptr = addWrap(head, left);
         end
      end else if (adv) begin
         n.ptr = addWrap(s.ptr, ADDR_ONE);
      end
      return n;
   endfunction

   // ==========================================================
   // write port: clear acts in its own cycle
   always_comb begin
      wrAddr = writeCtl.pointerClearN ? wrState.ptr : ADDR_ZERO;
      wrStore = !writeCtl.advanceGateN && !writeEnableN;
      next_wrState = stepPort(wrState, writeCtl, mode, 1'b1);
   end

   // write state and memory store
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         wrState <= PORT_RESET;
      end else if (ce) begin
         wrState <= next_wrState;
         if (wrStore) begin
            mem[wrAddr] <= writeData;
         end
      end
   end

   // ==========================================================
   // read port: a full buffer holds the pointer back while output enable is low
   always_comb begin
      rdAddr = readCtl.pointerClearN ? rdState.ptr : ADDR_ZERO;
      rdFetch = !readCtl.advanceGateN && !outputEnableN && bufReady;
      rdAdvOk = outputEnableN || bufReady;
      next_rdState = stepPort(rdState, readCtl, mode, rdAdvOk);
   end

   // read state
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rdState <= PORT_RESET;
      end else if (ce) begin
         rdState <= next_rdState;
      end
   end

   // ==========================================================
   // read data leaves through the buffer, registered
   fmp_pair_buffer #(
      .WIDTH(DATA_W),
      .DEPTH(BUF_DEPTH)
   ) u_buffer (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .ce(ce),
      .inValid(rdFetch),
      .inReady(bufReady),
      .inData(mem[rdAddr]),
      .outValid(readValid),
      .outReady(readReady),
      .outData(readData)
   );

   // pointer visibility
   assign writePointer = wrState.ptr;
   assign readPointer = rdState.ptr;
endmodule
`default_nettype wire

/* testbench/fmp_frame_memory_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// port checker for the frame memory
module fmp_frame_memory_asserts (
   input wire logic sys_clk, // clock
   input wire logic resetn, // sync reset, active low
   input wire logic ce, // clock enable
   input wire fmp_pkg::fmp_mode_t mode, // addressing mode
   input wire fmp_pkg::fmp_ctl_t writeCtl, // write controls
   input wire logic writeEnableN, // write enable
   input wire logic [fmp_pkg::DATA_W-1:0] writeData, // write byte
   input wire fmp_pkg::fmp_ctl_t readCtl, // read controls
   input wire logic outputEnableN, // output enable
   input wire logic [fmp_pkg::DATA_W-1:0] readData, // read byte
   input wire logic readValid, // read byte valid
   input wire logic readReady, // receiver takes byte
   input wire logic [fmp_pkg::ADDR_W-1:0] writePointer, // write pointer
   input wire logic [fmp_pkg::ADDR_W-1:0] readPointer // read pointer
);
   import fmp_pkg::*;
   logic wQuiet;
   logic rQuiet;
   // pointer controls idle apart from the advance gate
   assign wQuiet = ce & writeCtl.pointerResetN & writeCtl.jumpStrobeN
      & writeCtl.lineRestartN & writeCtl.pointerClearN;
   assign rQuiet = ce & readCtl.pointerResetN & readCtl.jumpStrobeN
      & readCtl.lineRestartN & readCtl.pointerClearN;
   // next pointer, wrapping at the end of memory
   function automatic logic [ADDR_W-1:0] inc(input logic [ADDR_W-1:0] p);
      return ({1'b0, p} == TOTAL_WORDS - 20'h00001) ? ADDR_ZERO : p + ADDR_ONE;
   endfunction
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // ==========================================================
   // pointer movement
   property p_wr_adv;
      wQuiet && !writeCtl.advanceGateN |=> writePointer == inc($past(writePointer));
   endproperty
   a_wr_adv: assert property (p_wr_adv) else $error("write pointer did not step");
   property p_wr_hold;
      wQuiet && writeCtl.advanceGateN |=> $stable(writePointer);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write pointer moved");
   property p_wr_clr;
      ce && !writeCtl.pointerClearN |=>
         writePointer == ($past(writeCtl.advanceGateN) ? ADDR_ZERO : ADDR_ONE);
   endproperty
   a_wr_clr: assert property (p_wr_clr) else $error("write clear missed");
   property p_rd_clr;
      ce && !readCtl.pointerClearN && readCtl.advanceGateN |=> readPointer == ADDR_ZERO;
   endproperty
   a_rd_clr: assert property (p_rd_clr) else $error("read clear missed");
   property p_rd_adv;
      rQuiet && !readCtl.advanceGateN && outputEnableN |=> readPointer == inc($past(readPointer));
   endproperty
   a_rd_adv: assert property (p_rd_adv) else $error("read pointer did not step");
   property p_wr_rst;
      ce && writeCtl.pointerClearN && writeCtl.jumpStrobeN && mode == FMP_LINEAR
         && $fell(writeCtl.pointerResetN) |=> writePointer == ADDR_ZERO;
   endproperty
   a_wr_rst: assert property (p_wr_rst) else $error("write reset missed");
   property p_rd_rst;
      ce && readCtl.pointerClearN && readCtl.jumpStrobeN && mode == FMP_LINEAR
         && $fell(readCtl.pointerResetN) |=> readPointer == ADDR_ZERO;
   endproperty
   a_rd_rst: assert property (p_rd_rst) else $error("read reset missed");
   // ==========================================================
   // read data handshake
   property p_rd_take;
      ce && !readCtl.advanceGateN && !outputEnableN && !readValid |=> readValid;
   endproperty
   a_rd_take: assert property (p_rd_take) else $error("read byte not offered");
   property p_rd_idle;
      ce && readCtl.advanceGateN && !readValid |=> !readValid;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read byte without gate");
   property p_rd_stand;
      ce && readValid && !readReady |=> readValid && $stable(readData);
   endproperty
   a_rd_stand: assert property (p_rd_stand) else $error("read byte dropped");
   c_wrap: cover property (wQuiet && !writeCtl.advanceGateN && writePointer == 19'h50fff);
   c_stall: cover property (readValid && !readReady ##1 readValid && !readReady);
   c_jump: cover property ($fell(writeCtl.pointerResetN) && !writeCtl.jumpStrobeN);
endmodule
bind fmp_frame_memory fmp_frame_memory_asserts u_fmpChk (.sys_clk(sys_clk), .resetn(resetn),
   .ce(ce), .mode(mode), .writeCtl(writeCtl), .writeEnableN(writeEnableN),
   .writeData(writeData), .readCtl(readCtl), .outputEnableN(outputEnableN),
   .readData(readData), .readValid(readValid), .readReady(readReady),
   .writePointer(writePointer), .readPointer(readPointer));
`default_nettype wire

/* testbench/fmp_jump_feeder.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// far-side serial jump address source for one port
module fmp_jump_feeder (
   input wire logic sys_clk, // clock
   input wire logic start, // begin a load
   input wire logic [3:0] bits, // address length
   input wire logic [14:0] addr, // jump address, right aligned
   output logic strobeN, // jump strobe, active low
   output logic serial // serial address bit
);
   int left = 0;
   initial begin
      strobeN = 1'b1;
      serial = 1'b0;
   end
   // strobe low for the whole load, msb first from its first cycle
   always @(posedge sys_clk) begin
      if (start && left == 0) begin
         left = int'(bits);
      end
      #1;
      if (left > 0) begin
         strobeN = 1'b0;
         serial = addr[left-1];
         left = left - 1;
      end else begin
         strobeN = 1'b1;
         serial = ~serial; // idle line keeps toggling
      end
   end
endmodule
`default_nettype wire

/* testbench/tb_fmp_frame_memory.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// self-checking bench for the frame memory ports
module tb_fmp_frame_memory;
   import fmp_pkg::*;
   typedef struct packed {
      logic ce;
      logic gateN;
      logic weN;
      logic [7:0] data;
      logic [18:0] ptr;
   } fmp_row_t;
   typedef struct packed {
      fmp_mode_t mode;
      logic [3:0] bits;
      logic [14:0] addr;
      logic [18:0] ptr;
      logic [18:0] wrap;
   } fmp_jump_t;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   fmp_mode_t mode = FMP_LINEAR;
   fmp_ctl_t wc = '1;
   fmp_ctl_t rc = '1;
   logic weN = 1'b1;
   logic [7:0] wd = 8'h00;
   logic oeN = 1'b0;
   logic ready = 1'b1;
   logic go = 1'b0;
   logic [3:0] bits = 4'he;
   logic [14:0] addr = 15'h0000;
   logic wStb, wSer, rStb, rSer, rv;
   logic [7:0] rd;
   logic [18:0] wp, rp;
   int errorCnt = 0;
   int checkCount = 0;
   int cycles = 0;
   fmp_row_t rows [6] = '{
      '{1'b1, 1'b0, 1'b0, 8'h11, 19'h1}, '{1'b1, 1'b0, 1'b1, 8'h22, 19'h2},
      '{1'b1, 1'b1, 1'b0, 8'h33, 19'h2}, '{1'b0, 1'b0, 1'b0, 8'h66, 19'h2},
      '{1'b1, 1'b0, 1'b0, 8'h44, 19'h3}, '{1'b1, 1'b0, 1'b0, 8'h55, 19'h4}};
   logic [7:0] expRd [4] = '{8'h11, 8'ha5, 8'h44, 8'h55};
   fmp_jump_t jumps [3] = '{'{FMP_LINEAR, 4'he, 15'h287f, 19'h50fe0, 19'h00000},
      '{FMP_GRID1024, 4'he, 15'h0060, 19'h00c00, 19'h00c20},
      '{FMP_GRID1152, 4'hf, 15'h0080, 19'h00900, 19'h00920}};
   always #5 sys_clk = ~sys_clk;
   fmp_jump_feeder wFeed (.sys_clk(sys_clk), .start(go), .bits(bits), .addr(addr),
      .strobeN(wStb), .serial(wSer));
   fmp_jump_feeder rFeed (.sys_clk(sys_clk), .start(go), .bits(bits), .addr(addr),
      .strobeN(rStb), .serial(rSer));
   fmp_frame_memory DUT (.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .mode(mode),
      .writeCtl({wc[6:5], wc[4] & wStb, wc[3:1], wSer}), .writeEnableN(weN), .writeData(wd),
      .readCtl({rc[6:5], rc[4] & rStb, rc[3:1], rSer}), .outputEnableN(oeN), .readData(rd),
      .readValid(rv), .readReady(ready), .writePointer(wp), .readPointer(rp));
   // ==========================================================
   // shared tasks
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [18:0] seen, input logic [18:0] want);
      checkCount++;
      if (seen !== want) begin
         errorCnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic conclude;
      if (errorCnt == 0 && checkCount > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic clr;
      wc.pointerClearN = 1'b0;
      rc.pointerClearN = 1'b0;
      step(1);
      wc.pointerClearN = 1'b1;
      rc.pointerClearN = 1'b1;
      chk(wp, 19'h0);
      chk(rp, 19'h0);
   endtask
   // run limit
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         errorCnt++;
         conclude();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      step(16);
      resetn = 1'b1;
      clr();
      wc.advanceGateN = 1'b0;
      weN = 1'b0;
      wd = 8'ha5;
      step(4);
      wc.advanceGateN = 1'b1;
      weN = 1'b1;
      clr();
      foreach (rows[i]) begin
         ce = rows[i].ce;
         wc.advanceGateN = rows[i].gateN;
         weN = rows[i].weN;
         wd = rows[i].data;
         step(1);
         chk(wp, rows[i].ptr);
      end
      ce = 1'b1;
      wc.advanceGateN = 1'b1;
      weN = 1'b1;
      rc.advanceGateN = 1'b0;
      for (int i = 0; i < 4; i++) begin
         step(1);
         chk(19'(rv), 19'h1);
         chk(19'(rd), 19'(expRd[i]));
      end
      rc.advanceGateN = 1'b1;
      step(1);
      chk(19'(rv), 19'h0);
      chk(rp, 19'h4);
      clr();
      ready = 1'b0;
      rc.advanceGateN = 1'b0;
      step(3);
      chk(rp, 19'h2);
      chk(19'(rd), 19'h11);
      ready = 1'b1;
      step(1);
      chk(19'(rd), 19'ha5);
      oeN = 1'b1;
      step(2);
      rc.advanceGateN = 1'b1;
      oeN = 1'b0;
      resetn = 1'b0;
      step(1);
      resetn = 1'b1;
      chk(19'(rv), 19'h0);
      foreach (jumps[i]) begin
         mode = jumps[i].mode;
         bits = jumps[i].bits;
         addr = jumps[i].addr;
         go = 1'b1;
         step(1);
         go = 1'b0;
         step(16);
         wc[5:4] = 2'b00;
         rc[5:4] = 2'b00;
         step(1);
         chk(wp, jumps[i].ptr);
         chk(rp, jumps[i].ptr);
         wc[5:4] = 2'b11;
         rc[5:4] = 2'b11;
         wc.advanceGateN = 1'b0;
         step(32);
         wc.advanceGateN = 1'b1;
         chk(wp, jumps[i].wrap);
      end
      wc.advanceGateN = 1'b0;
      step(5);
      wc.advanceGateN = 1'b1;
      wc.lineRestartN = 1'b0;
      step(1);
      chk(wp, 19'h00d80);
      wc.advanceGateN = 1'b0;
      step(3);
      wc.advanceGateN = 1'b1;
      wc.pointerResetN = 1'b0;
      step(1);
      chk(wp, 19'h00d80);
      // strobe falls while reset is held low: jump and open a window
      wc.lineRestartN = 1'b1;
      step(1);
      wc.jumpStrobeN = 1'b0;
      wc.windowSelectN = 1'b0;
      step(1);
      chk(wp, 19'h00900);
      wc[5:4] = 2'b11;
      wc.windowSelectN = 1'b1;
      wc.advanceGateN = 1'b0;
      step(2);
      wc.advanceGateN = 1'b1;
      wc.pointerResetN = 1'b0;
      step(1);
      chk(wp, 19'h00900);
      wc = '1;
      mode = FMP_LINEAR;
      step(1);
      wc[5:4] = 2'b00;
      wc.pointerClearN = 1'b0;
      rc.pointerResetN = 1'b0;
      step(1);
      chk(wp, 19'h0);
      chk(rp, 19'h0);
      wc = '1;
      rc = '1;
      step(2);
      // cleared window no longer redirects a reset
      wc.pointerResetN = 1'b0;
      step(1);
      chk(wp, 19'h0);
      wc.pointerResetN = 1'b1;
      step(1);
      conclude();
   end
endmodule
`default_nettype wire
